// ### verilog/scf_pkg.sv
`default_nettype none
package scf_pkg;
  localparam int CLK_HZ     = 50_000_000;
  localparam int BAUD_9600  = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_57600 = 57600;
  localparam logic [12:0] DIV_19200 = 13'(CLK_HZ / BAUD_19200);
  localparam logic [12:0] DIV_38400 = 13'(CLK_HZ / BAUD_38400);
  localparam logic [12:0] DIV_57600 = 13'(CLK_HZ / BAUD_57600);

  localparam logic [9:0] BUF_BYTES = 10'h200;
  localparam logic [9:0] XOFF_LVL  = 10'h1c0;
  localparam logic [9:0] XON_LVL   = 10'h100;
  localparam logic [9:0] RTS_LVL   = 10'h1f0;
  localparam logic [4:0] EQ_DEPTH  = 5'h14;
  localparam logic [4:0] EQ_LAST   = 5'h13;

  // Control register fields
  localparam int CTL_BAUD = 0;
  localparam int CTL_PAR  = 2;
  localparam int CTL_FLOW = 4;
  localparam int CTL_TERM = 6;
  localparam int CTL_EN   = 8;
  localparam logic [8:0] CTRL_RST = 9'h100;

  // Word addresses
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h1;
  localparam logic [3:0] REG_HDR0  = 4'h2;
  localparam logic [3:0] REG_HDR1  = 4'h3;
  localparam logic [3:0] REG_P1VAL = 4'h4;
  localparam logic [3:0] REG_P1FMT = 4'h5;
  localparam logic [3:0] REG_P2VAL = 4'h6;
  localparam logic [3:0] REG_P2FMT = 4'h7;
  localparam logic [3:0] REG_ERRQ  = 4'h8;
  localparam logic [3:0] REG_TXDAT = 4'h9;
  localparam logic [3:0] REG_ACK   = 4'ha;

  localparam logic [7:0] ERR_SYNTAX = 8'h01;
  localparam logic [7:0] ERR_OVFL   = 8'h02;
  localparam logic [7:0] ERR_PARITY = 8'h03;
  localparam logic [7:0] ERR_FRAME  = 8'h04;
  localparam logic [7:0] ERR_PARAM  = 8'h05;
  localparam logic [7:0] ERR_HDRLEN = 8'h06;
  localparam logic [7:0] ERR_WIDE   = 8'h07;

  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_XON   = 8'h11;
  localparam logic [7:0] CH_XOFF  = 8'h13;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_E     = 8'h45;

  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01, PAR_EVEN = 2'b10} scf_par_t;
  typedef enum logic [1:0] {FLOW_NONE = 2'b00, FLOW_SW = 2'b01, FLOW_HW = 2'b10} scf_flow_t;
  typedef enum logic [1:0] {TERM_CR = 2'b00, TERM_LF = 2'b01, TERM_CRLF = 2'b10} scf_term_t;
  typedef enum logic [1:0] {FMT_NR1 = 2'b00, FMT_NR2 = 2'b01, FMT_NR3 = 2'b10} scf_fmt_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
                            RX_STOP = 2'b11} scf_rx_t;
  typedef enum logic [1:0] {PS_HDR = 2'b00, PS_PRM = 2'b01, PS_SKIP = 2'b10} scf_ps_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } scf_bus_t;

  typedef struct packed {
    logic        sgn;
    logic        neg;
    logic        dig;
    logic        point;
    logic [31:0] mant;
    logic [3:0]  frac;
    logic        esgn;
    logic        eneg;
    logic        edig;
    logic [7:0]  expo;
    scf_fmt_t    fmt;
  } scf_prm_t;
endpackage
`default_nettype wire

// ### verilog/scf_top.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module scf_top
  import scf_pkg::*;
#(
  parameter logic [12:0] DIV_9600 = 13'(CLK_HZ / BAUD_9600)
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire scf_bus_t    bus_req,
  output var  logic [31:0] rdata,
  input  wire logic        rxd,
  output var  logic        txd,
  input  wire logic        cts_n,
  output var  logic        rts_n,
  input  wire logic [7:0]  panel_key,
  input  wire logic        local_key,
  output var  logic [7:0]  panel_key_out,
  output var  logic        remote_ind,
  output var  logic        err_ind
);
  typedef struct packed {
    logic [8:0]            ctrl;
    logic [31:0]           rdata;
    scf_rx_t               rx_st;
    logic [12:0]           rx_cnt;
    logic [3:0]            rx_bit;
    logic [8:0]            rx_sh;
    logic                  prev_cr;
    logic                  discard;
    logic                  tx_busy;
    logic [12:0]           tx_cnt;
    logic [3:0]            tx_bit;
    logic [9:0]            tx_sh;
    logic                  txd;
    logic                  xoff_rcvd;
    logic                  xoff_sent;
    logic                  rts_n;
    logic [511:0][7:0]     ibuf;
    logic [9:0]            iwr;
    logic [9:0]            ird;
    logic [9:0]            icom;
    logic [511:0][7:0]     obuf;
    logic [9:0]            owr;
    logic [9:0]            ord;
    scf_ps_t               ps;
    logic [4:0][7:0]       hdr;
    logic [2:0]            hlen;
    scf_prm_t [1:0]        prm;
    logic                  pidx;
    logic [1:0]            pcnt;
    logic                  cmd_rdy;
    logic [19:0][7:0]      eq;
    logic [4:0]            eq_head;
    logic [4:0]            eq_cnt;
    logic [7:0]            rx_err;
    logic                  remote;
    logic [7:0]            panel;
    logic                  err_ind;
  } scf_state_t;

  scf_state_t q;
  scf_state_t d;

  function automatic logic [4:0] eq_add(input logic [4:0] a, input logic [4:0] b);
    logic [5:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, EQ_DEPTH}) begin
      s = s - {1'b0, EQ_DEPTH};
    end
    return s[4:0];
  endfunction

  function automatic logic prm_ok(input scf_prm_t p);
    return p.dig && ((p.fmt != FMT_NR3) || p.edig);
  endfunction

  function automatic logic [31:0] prm_val(input scf_prm_t p);
    return p.neg ? 32'h0 - p.mant : p.mant;
  endfunction

  function automatic logic [31:0] prm_fmt(input scf_prm_t p);
    logic [7:0] e;
    e = p.eneg ? 8'h00 - p.expo : p.expo;
    return {16'h0000, e, p.frac, 2'b00, p.fmt};
  endfunction

  always_comb begin
    logic [12:0] bdiv;
    logic [9:0]  icnt;
    logic [9:0]  ocnt;
    logic        par_on;
    logic [7:0]  rbyte;
    logic        rpar;
    logic        is_term;
    logic        want_off;
    logic        tx_ok;
    logic        load;
    logic [7:0]  tch;
    logic [7:0]  ch;
    logic [7:0]  uc;
    logic        done;
    logic [7:0]  perr;
    scf_prm_t    p;
    logic        pop;
    logic [7:0]  pcode;
    logic        rx_set;
    bdiv     = DIV_9600;
    icnt     = q.iwr - q.ird;
    ocnt     = q.owr - q.ord;
    par_on   = q.ctrl[CTL_PAR +: 2] != PAR_NONE;
    rbyte    = par_on ? q.rx_sh[7:0] : q.rx_sh[8:1];
    rpar     = (q.ctrl[CTL_PAR +: 2] == PAR_ODD) ? ~^rbyte : ^rbyte;
    is_term  = 1'b0;
    want_off = 1'b0;
    tx_ok    = 1'b0;
    load     = 1'b0;
    tch      = 8'h00;
    ch       = q.ibuf[q.ird[8:0]];
    uc       = ch;
    done     = 1'b0;
    perr     = 8'h00;
    p        = q.prm[q.pidx];
    pop      = 1'b0;
    pcode    = 8'h00;
    rx_set   = 1'b0;
    d        = q;
    d.rdata  = 32'h0;

    unique case (q.ctrl[CTL_BAUD +: 2])
      2'b00: bdiv = DIV_9600;
      2'b01: bdiv = DIV_19200;
      2'b10: bdiv = DIV_38400;
      2'b11: bdiv = DIV_57600;
    endcase

    // Receiver, mid-bit sampling
    unique case (q.rx_st)
      RX_IDLE: begin
        if (!rxd) begin
          d.rx_st  = RX_START;
          d.rx_cnt = {1'b0, bdiv[12:1]};
        end
      end
      RX_START: begin
        if (q.rx_cnt != 13'h0) begin
          d.rx_cnt = q.rx_cnt - 13'h1;
        end else begin
          d.rx_st  = rxd ? RX_IDLE : RX_DATA;
          d.rx_cnt = bdiv - 13'h1;
          d.rx_bit = 4'h0;
        end
      end
      RX_DATA: begin
        if (q.rx_cnt != 13'h0) begin
          d.rx_cnt = q.rx_cnt - 13'h1;
        end else begin
          d.rx_sh  = {rxd, q.rx_sh[8:1]};
          d.rx_bit = q.rx_bit + 4'h1;
          d.rx_cnt = bdiv - 13'h1;
          if (q.rx_bit == (par_on ? 4'h8 : 4'h7)) begin
            d.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (q.rx_cnt != 13'h0) begin
          d.rx_cnt = q.rx_cnt - 13'h1;
        end else begin
          d.rx_st = RX_IDLE;
          if (!q.ctrl[CTL_EN]) begin
            d.rx_st = RX_IDLE;
          end else if (!rxd) begin
            d.rx_err = ERR_FRAME;
            rx_set   = 1'b1;
          end else if (par_on && rpar != q.rx_sh[8]) begin
            d.rx_err = ERR_PARITY;
            rx_set   = 1'b1;
          end else if (q.ctrl[CTL_FLOW +: 2] == FLOW_SW &&
                       (rbyte == CH_XON || rbyte == CH_XOFF)) begin
            d.xoff_rcvd = rbyte == CH_XOFF;
          end else begin
            unique case (q.ctrl[CTL_TERM +: 2])
              TERM_CR:   is_term = rbyte == CH_CR;
              TERM_LF:   is_term = rbyte == CH_LF;
              default:   is_term = rbyte == CH_LF && q.prev_cr;
            endcase
            d.prev_cr = rbyte == CH_CR;
            if (is_term) begin
              if (q.discard || icnt == BUF_BYTES) begin
                d.iwr     = q.icom;
                d.discard = 1'b0;
                d.rx_err  = ERR_OVFL;
                rx_set    = 1'b1;
              end else begin
                d.ibuf[q.iwr[8:0]] = CH_LF;
                d.iwr  = q.iwr + 10'h1;
                d.icom = q.iwr + 10'h1;
              end
            end else if (icnt == BUF_BYTES) begin
              d.discard = 1'b1;
            end else if (!q.discard) begin
              d.ibuf[q.iwr[8:0]] = (rbyte == CH_LF) ? CH_CR : rbyte;
              d.iwr = q.iwr + 10'h1;
            end
          end
        end
      end
    endcase

    // Transmitter and flow control, in-band XON/XOFF and RTS/CTS
    want_off = q.xoff_sent ? (icnt > XON_LVL) : (icnt >= XOFF_LVL);
    unique case (q.ctrl[CTL_FLOW +: 2])
      FLOW_SW: tx_ok = !q.xoff_rcvd;
      FLOW_HW: tx_ok = !cts_n;
      default: tx_ok = 1'b1;
    endcase
    d.rts_n = (q.ctrl[CTL_FLOW +: 2] == FLOW_HW) && (icnt >= RTS_LVL);
    if (q.ctrl[CTL_FLOW +: 2] != FLOW_SW) begin
      d.xoff_sent = 1'b0;
      d.xoff_rcvd = 1'b0;
    end
    if (!q.tx_busy) begin
      if (q.ctrl[CTL_FLOW +: 2] == FLOW_SW && want_off != q.xoff_sent) begin
        tch         = want_off ? CH_XOFF : CH_XON;
        d.xoff_sent = want_off;
        load        = 1'b1;
      end else if (ocnt != 10'h0 && tx_ok) begin
        tch   = q.obuf[q.ord[8:0]];
        d.ord = q.ord + 10'h1;
        load  = 1'b1;
      end
      if (load) begin
        d.txd     = 1'b0;
        d.tx_busy = 1'b1;
        d.tx_cnt  = bdiv - 13'h1;
        d.tx_sh   = par_on ? {1'b1, (q.ctrl[CTL_PAR +: 2] == PAR_ODD) ? ~^tch : ^tch, tch}
                           : {2'b11, tch};
        d.tx_bit  = par_on ? 4'ha : 4'h9;
      end
    end else if (q.tx_cnt != 13'h0) begin
      d.tx_cnt = q.tx_cnt - 13'h1;
    end else if (q.tx_bit == 4'h0) begin
      d.tx_busy = 1'b0;
    end else begin
      d.txd    = q.tx_sh[0];
      d.tx_sh  = {1'b1, q.tx_sh[9:1]};
      d.tx_bit = q.tx_bit - 4'h1;
      d.tx_cnt = bdiv - 13'h1;
    end

    // Parser, one buffered byte per cycle
    if (q.ird != q.icom && !q.cmd_rdy) begin
      d.ird = q.ird + 10'h1;
      if (ch >= 8'h61 && ch <= 8'h7a) begin
        uc = ch - 8'h20;
      end
      unique case (q.ps)
        PS_HDR: begin
          if (ch == CH_CR) begin
            d.ps = PS_HDR;
          end else if (ch == CH_LF) begin
            if (q.hlen >= 3'h3) begin
              done = 1'b1;
            end else if (q.hlen != 3'h0) begin
              perr = ERR_HDRLEN;
            end
          end else if (ch[7]) begin
            perr = ERR_WIDE;
          end else if (ch == CH_SP) begin
            if (q.hlen >= 3'h3) begin
              d.ps   = PS_PRM;
              d.pidx = 1'b0;
              d.pcnt = 2'h1;
            end else begin
              perr = ERR_HDRLEN;
            end
          end else if (ch < CH_SP || ch == CH_COMMA) begin
            perr = ERR_SYNTAX;
          end else if (q.hlen == 3'h5) begin
            perr = ERR_HDRLEN;
          end else begin
            d.hdr[q.hlen] = uc;
            d.hlen = q.hlen + 3'h1;
          end
        end
        PS_PRM: begin
          if (ch == CH_CR) begin
            d.ps = PS_PRM;
          end else if (ch == CH_LF) begin
            if (prm_ok(p)) done = 1'b1;
            else perr = ERR_SYNTAX;
          end else if (ch == CH_COMMA && q.pidx == 1'b0 && prm_ok(p)) begin
            d.pidx = 1'b1;
            d.pcnt = 2'h2;
          end else if ((ch == CH_PLUS || ch == CH_MINUS) && p.fmt != FMT_NR3 &&
                       !p.sgn && !p.dig && !p.point) begin
            p.sgn = 1'b1;
            p.neg = ch == CH_MINUS;
          end else if ((ch == CH_PLUS || ch == CH_MINUS) && p.fmt == FMT_NR3 &&
                       !p.esgn && !p.edig) begin
            p.esgn = 1'b1;
            p.eneg = ch == CH_MINUS;
          end else if (ch >= 8'h30 && ch <= 8'h39) begin
            if (p.fmt == FMT_NR3) begin
              p.expo = (p.expo << 3) + (p.expo << 1) + {4'h0, ch[3:0]};
              p.edig = 1'b1;
            end else begin
              p.mant = (p.mant << 3) + (p.mant << 1) + {28'h0, ch[3:0]};
              p.dig  = 1'b1;
              if (p.point) p.frac = p.frac + 4'h1;
            end
          end else if (ch == CH_DOT && !p.point && p.fmt == FMT_NR1) begin
            p.point = 1'b1;
            p.dig   = 1'b1;
            p.fmt   = FMT_NR2;
          end else if (uc == CH_E && p.fmt == FMT_NR2) begin
            p.fmt = FMT_NR3;
          end else begin
            perr = ch[7] ? ERR_WIDE : ERR_SYNTAX;
          end
          if (perr == 8'h00) d.prm[q.pidx] = p;
        end
        default: begin
          if (ch == CH_LF) d.ps = PS_HDR;
        end
      endcase
      if (perr != 8'h00) begin
        pcode  = perr;
        d.ps   = (ch == CH_LF) ? PS_HDR : PS_SKIP;
        d.hlen = 3'h0;
        d.pcnt = 2'h0;
        d.prm  = '0;
      end
      if (done) begin
        d.cmd_rdy = 1'b1;
        d.ps      = PS_HDR;
      end
    end

    // Register port
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        REG_CTRL:  d.ctrl = bus_req.wdata[8:0];
        REG_TXDAT: begin
          if (ocnt != BUF_BYTES) begin
            d.obuf[q.owr[8:0]] = bus_req.wdata[7:0];
            d.owr = q.owr + 10'h1;
          end
        end
        REG_ACK: begin
          if (bus_req.wdata[0] && q.cmd_rdy) begin
            d.cmd_rdy = 1'b0;
            d.hlen    = 3'h0;
            d.pcnt    = 2'h0;
            d.prm     = '0;
            if (bus_req.wdata[1]) pcode = ERR_PARAM;
          end
          if (bus_req.wdata[2]) d.remote = 1'b0;
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        REG_CTRL:  d.rdata = {23'h0, q.ctrl};
        REG_STAT:  d.rdata = {2'h0, ocnt, icnt, 1'b0, q.eq_cnt, q.xoff_rcvd,
                              ocnt == BUF_BYTES, q.cmd_rdy, q.remote};
        REG_HDR0:  d.rdata = {q.hdr[3], q.hdr[2], q.hdr[1], q.hdr[0]};
        REG_HDR1:  d.rdata = {16'h0, q.prm[1].fmt == FMT_NR1, q.prm[0].fmt == FMT_NR1,
                              q.pcnt, 1'b0, q.hlen, q.hdr[4]};
        REG_P1VAL: d.rdata = prm_val(q.prm[0]);
        REG_P1FMT: d.rdata = prm_fmt(q.prm[0]);
        REG_P2VAL: d.rdata = prm_val(q.prm[1]);
        REG_P2FMT: d.rdata = prm_fmt(q.prm[1]);
        REG_ERRQ: begin
          if (q.eq_cnt != 5'h0) begin
            d.rdata = {24'h0, q.eq[q.eq_head]};
            pop     = 1'b1;
          end
        end
        default:   d.rdata = 32'h0;
      endcase
    end

    // Error queue; a receiver error waits while the parser pushes
    if (pcode == 8'h00 && q.rx_err != 8'h00) begin
      pcode = q.rx_err;
      // A fresh receiver error in this cycle wins over the clear
      if (!rx_set) d.rx_err = 8'h00;
    end
    if (pop) begin
      d.eq_head = (q.eq_head == EQ_LAST) ? 5'h0 : q.eq_head + 5'h1;
      d.eq_cnt  = q.eq_cnt - 5'h1;
    end
    if (pcode != 8'h00) begin
      if (d.eq_cnt == EQ_DEPTH) begin
        d.eq[d.eq_head] = pcode;
        d.eq_head = (d.eq_head == EQ_LAST) ? 5'h0 : d.eq_head + 5'h1;
      end else begin
        d.eq[eq_add(d.eq_head, d.eq_cnt)] = pcode;
        d.eq_cnt = d.eq_cnt + 5'h1;
      end
    end
    d.err_ind = d.eq_cnt != 5'h0;

    // Remote and local
    if (local_key) d.remote = 1'b0;
    if (done) d.remote = 1'b1;
    d.panel = q.remote ? 8'h00 : panel_key;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q         <= '0;
      q.ctrl    <= CTRL_RST;
      q.txd     <= 1'b1;
      q.tx_sh   <= '1;
    end else begin
      q <= d;
    end
  end

  assign rdata         = q.rdata;
  assign txd           = q.txd;
  assign rts_n         = q.rts_n;
  assign panel_key_out = q.panel;
  assign remote_ind    = q.remote;
  assign err_ind       = q.err_ind;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  stop_bit_high_a: assert property (q.tx_busy && q.tx_bit == 4'h0 |-> q.txd)
    else $error("stop bit not high");
  tx_parity_ok_a: assert property ($rose(q.tx_busy) && q.ctrl[CTL_PAR +: 2] == PAR_EVEN
    |-> ^q.tx_sh[8:0] == 1'b0)
    else $error("even parity wrong");
  cts_hold_a: assert property (q.ctrl[CTL_FLOW +: 2] == FLOW_HW && cts_n && !q.tx_busy
    |=> !q.tx_busy)
    else $error("sent without clear to send");
  rts_full_a: assert property (q.ctrl[CTL_FLOW +: 2] == FLOW_HW
    && (q.iwr - q.ird) >= RTS_LVL |=> rts_n)
    else $error("request to send left on");
  ibuf_bound_a: assert property ((q.iwr - q.ird) <= BUF_BYTES)
    else $error("input buffer overrun");
  parse_commit_a: assert property ((q.icom - q.ird) <= (q.iwr - q.ird))
    else $error("parser past terminator");
  cmd_hold_a: assert property (q.cmd_rdy && !bus_req.wr |=> $stable(q.ird))
    else $error("parser ran during pending command");
  errq_full_a: assert property (q.eq_cnt == EQ_DEPTH && !(bus_req.rd && bus_req.addr == REG_ERRQ)
    |=> q.eq_cnt == EQ_DEPTH)
    else $error("error queue lost its level");
  remote_panel_a: assert property (q.remote |=> panel_key_out == 8'h00)
    else $error("panel key passed in remote");
  hdr_size_a: assert property ($rose(q.cmd_rdy) |-> q.hlen >= 3'h3 && q.hlen <= 3'h5
    && q.pcnt <= 2'h2 && remote_ind)
    else $error("bad accepted header");
  iface_off_a: assert property (!q.ctrl[CTL_EN] |=> $stable(q.iwr))
    else $error("traffic taken while deselected");
endmodule
`default_nettype wire

// ### tb/scf_host.sv
`timescale 1ns/10ps
`default_nettype none
module scf_host #(
  parameter int DIV = 16
) (
  input  wire logic clock,
  output var  logic rxd,
  input  wire logic txd
);
  logic [7:0] got;
  int         got_n;
  initial begin
    rxd   = 1'b1;
    got_n = 0;
  end
  // Flip spoils parity on purpose
  task automatic send(input logic [7:0] b, input logic [1:0] par, input logic flip);
    logic [10:0] f;
    int          n;
    f = {1'b1, ((par == 2'b10) ? ^b : ~^b) ^ flip, b, 1'b0};
    n = (par == 2'b00) ? 10 : 11;
    if (par == 2'b00) f[9] = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rxd <= f[i];
      repeat (DIV - 1) @(posedge clock);
    end
  endtask
  task automatic msg(input string s, input logic [1:0] par);
    for (int i = 0; i < s.len(); i++) send(8'(s[i]), par, 1'b0);
  endtask
  initial forever begin
    @(negedge txd);
    repeat (DIV + DIV / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      got[i] = txd;
      repeat (DIV) @(posedge clock);
    end
    got_n++;
  end
endmodule
`default_nettype wire

// ### tb/test_scf_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_scf_top;
  import scf_pkg::*;
  localparam int DIV = 16;
  logic        clock, rst, rxd, txd, cts_n, rts_n, local_key, remote_ind, err_ind;
  logic [7:0]  panel_key, panel_key_out;
  logic [31:0] rdata, v;
  scf_bus_t    bus_req;
  int          err_count, checks;
  scf_top #(.DIV_9600(13'(DIV))) i_dut (.clock(clock), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n),
    .panel_key(panel_key), .local_key(local_key), .panel_key_out(panel_key_out),
    .remote_ind(remote_ind), .err_ind(err_ind));
  scf_host #(.DIV(DIV)) i_host (.clock(clock), .rxd(rxd), .txd(txd));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    bus_req <= '0;
    #1 v = rdata;
  endtask
  task automatic poll(input int b, input logic val);
    for (int i = 0; i < 200; i++) begin
      rd(REG_STAT);
      if (v[b] === val) break;
    end
    chk(32'(v[b]), 32'(val));
  endtask
  task automatic cmd(input string s, input logic [1:0] par);
    i_host.msg(s, par);
    i_host.send(CH_CR, par, 1'b0);
    poll(1, 1'b1);
  endtask
  task automatic pnl(input logic [7:0] k, input logic [7:0] exp);
    panel_key <= k;
    repeat (2) @(posedge clock);
    #1 chk(32'(panel_key_out), 32'(exp));
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    tally_and_finish;
  end
  initial begin
    bus_req = '0;
    rst = 1'b1;
    cts_n = 1'b0;
    local_key = 1'b0;
    panel_key = 8'h00;
    err_count = 0;
    checks = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(REG_CTRL); chk(v, 32'h100);
    rd(REG_STAT); chk(v, 32'h0);
    chk(32'(txd), 32'h1);
    pnl(8'h5a, 8'h5a);
    cmd("vLt +12", 2'b00);
    rd(REG_HDR0); chk(v & 32'h00ffffff, 32'h00544c56);
    rd(REG_HDR1); chk(32'(v[14:8]), 32'h53);
    rd(REG_P1VAL); chk(v, 32'hc);
    rd(REG_P1FMT); chk(v & 32'hf3, 32'h0);
    chk(32'(remote_ind), 32'h1);
    pnl(8'h3c, 8'h00);
    local_key <= 1'b1;
    @(posedge clock);
    local_key <= 1'b0;
    pnl(8'h3c, 8'h3c);
    wr(REG_ACK, 32'h1);
    cmd("LMV -.5", 2'b00);
    rd(REG_P1VAL); chk(v, 32'hfffffffb);
    rd(REG_P1FMT); chk(v & 32'hf3, 32'h11);
    wr(REG_ACK, 32'h1);
    cmd("out 1,8.9E-1", 2'b00);
    rd(REG_HDR1); chk(32'(v[15:12]), 32'h6);
    rd(REG_P2VAL); chk(v, 32'd89);
    rd(REG_P2FMT); chk(v & 32'hfff3, 32'hff12);
    wr(REG_ACK, 32'h5);
    i_host.msg("ab", 2'b00);
    i_host.send(CH_CR, 2'b00, 1'b0);
    poll(4, 1'b1);
    chk(32'(err_ind), 32'h1);
    wr(REG_CTRL, 32'h108);
    for (int i = 0; i < 20; i++) i_host.send(8'h41, 2'b10, 1'b1);
    repeat (4) @(posedge clock);
    rd(REG_STAT); chk(32'(v[8:4]), 32'h14);
    rd(REG_ERRQ); chk(v, 32'(ERR_PARITY));
    for (int i = 0; i < 19; i++) rd(REG_ERRQ);
    rd(REG_ERRQ); chk(v, 32'h0);
    chk(32'(err_ind), 32'h0);
    cmd("OUT 2", 2'b10);
    wr(REG_ACK, 32'h1);
    wr(REG_CTRL, 32'h000);
    i_host.msg("OMD 1", 2'b00);
    i_host.send(CH_CR, 2'b00, 1'b0);
    rd(REG_STAT); chk(v & 32'hfffffc02, 32'h0);
    wr(REG_CTRL, 32'h140);
    i_host.msg("OMD 1", 2'b00);
    rd(REG_STAT); chk(32'(v[1]), 32'h0);
    i_host.send(CH_LF, 2'b00, 1'b0);
    poll(1, 1'b1);
    wr(REG_TXDAT, 32'h5a);
    for (int i = 0; i < 400 && i_host.got_n == 0; i++) @(posedge clock);
    chk(32'(i_host.got), 32'h5a);
    chk(32'(rts_n), 32'h0);
    cts_n <= 1'b1;
    wr(REG_CTRL, 32'h120);
    wr(REG_TXDAT, 32'ha5);
    repeat (200) @(posedge clock);
    chk(32'(txd), 32'h1);
    chk(i_host.got_n, 1);
    cts_n <= 1'b0;
    for (int i = 0; i < 400 && i_host.got_n == 1; i++) @(posedge clock);
    chk(32'(i_host.got), 32'ha5);
    tally_and_finish;
  end
endmodule
`default_nettype wire
